/* File: uspm_pkg.sv */
// Constants and types for the upstream port miscellaneous configuration registers.
// Assumes configuration accesses arrive as word-aligned byte addresses.
package uspm_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned NUM_PORTS  = 8;
  localparam int unsigned PORT_SEL_W = 3;
  localparam int unsigned LTSSM_W    = 10;
  localparam int unsigned NUM_PINS   = 2;

  localparam logic [ADDR_W-1:0] OFF_EEPROM_WORD = 8'ha4;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_CTRL  = 8'ha8;
  localparam logic [ADDR_W-1:0] OFF_DEBUG_VALUE = 8'hac;
  localparam logic [ADDR_W-1:0] OFF_SUBSYS_CAP  = 8'hb0;
  localparam logic [ADDR_W-1:0] OFF_SUBSYS_ID   = 8'hb4;
  localparam logic [ADDR_W-1:0] OFF_PIN_CTRL    = 8'hb8;
  localparam logic [1:0]        WORD_ALIGN_MASK = 2'h3;

  localparam int unsigned EE_ADDR_LSB    = 0;
  localparam int unsigned EE_DATA_LSB    = 16;
  localparam int unsigned DBG_MODE_LSB   = 0;
  localparam int unsigned DBG_MODE_W     = 5;
  localparam int unsigned DBG_PORT_LSB   = 5;
  localparam int unsigned DBG_START_BIT  = 8;
  localparam int unsigned CAP_ID_LSB     = 0;
  localparam int unsigned CAP_NEXT_LSB   = 8;
  localparam int unsigned VENDOR_LSB     = 0;
  localparam int unsigned DEVICE_LSB     = 16;
  localparam int unsigned PIN_GROUP_W    = 4;
  localparam int unsigned PIN_IN_BIT     = 0;
  localparam int unsigned PIN_OE_BIT     = 1;
  localparam int unsigned PIN_VAL_BIT    = 2;

  localparam logic [DBG_MODE_W-1:0] DBG_MODE_LTSSM = 5'h0c;
  localparam logic [LTSSM_W-1:0]    LTSSM_MASK     = 10'h35f;
  localparam logic [7:0]            CAP_ID_SUBSYS  = 8'h0d;
  localparam logic [7:0]            CAP_NEXT_PTR   = 8'hc0;

  localparam logic [15:0]         RST_WORD16  = 16'h0000;
  localparam logic [DATA_W-1:0]   RST_WORD32  = 32'h0000_0000;
  localparam logic [NUM_PINS-1:0] RST_PIN_IN  = 2'h3;
  localparam logic [NUM_PINS-1:0] RST_PIN_OFF = 2'h0;
  localparam logic [NUM_PINS-1:0] RST_OE_N    = 2'h3;

  typedef struct packed {
    logic [15:0]           ee_addr;
    logic [15:0]           ee_data;
    logic [DBG_MODE_W-1:0] dbg_mode;
    logic [PORT_SEL_W-1:0] dbg_port;
    logic                  dbg_start;
    logic [DATA_W-1:0]     dbg_value;
    logic [15:0]           vendor;
    logic [15:0]           device;
    logic [NUM_PINS-1:0]   pin_in;
    logic [NUM_PINS-1:0]   pin_oe;
    logic [NUM_PINS-1:0]   pin_val;
    logic [NUM_PINS-1:0]   pin_drive;
    logic [NUM_PINS-1:0]   pin_oe_n;
    logic [DATA_W-1:0]     rdata;
    logic                  rvalid;
  } uspm_state_t;

endpackage

/* File: uspm_regs.sv */
// Upstream port miscellaneous configuration registers: EEPROM word, debug output,
// subsystem identification and general-purpose pin control for pins 0 and 1.
// Assumes single-cycle configuration read and write strobes synchronous to clk_i.
//
// Overview of operation
// - EEPROM data is read-write in bits 31:16 of the EEPROM word, reset zero.
// - EEPROM address is read-write in bits 15:0 of that word, reset zero.
// - Debug mode selector bits 4:0 read-write, reset zero; value 0Ch selects training states.
// - Debug port selector bits 7:5 and start bit 8, read-write, reset zero.
// - Debug data word is read-only, follows selected debug output, resets to zero.
// - Training mode: bit 0 detect, bit 1 polling, bit 2 configuring.
// - Training mode: bit 3 link up L0, bit 4 L1, bit 6 L2.
// - Training mode: bit 8 hot reset, bit 9 recovery.
// - Subsystem capability header returns identifier 0Dh in bits 7:0.
// - Header bits 15:8 return next-capability pointer C0h.
// - Subsystem vendor code read-only in bits 15:0, reset zero, loadable.
// - Subsystem device code read-only in bits 31:16, reset zero, loadable.
// - Debug, EEPROM and pin control registers exist only in the upstream function.
// - Pin input bits 0 and 4 reflect pin level, reset to one.
// - Pin output-enable bits 1 and 5: zero input, one output, reset zero.
// - Pin output value bit drives the pin when configured as output.
// - Output value bits 2 and 6 act only while port power event is disabled.
// - With power event enabled, that port's power bit drives the pin instead.
`timescale 1ns/10ps

module uspm_regs
  import uspm_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  cfg_up_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic [ADDR_W-1:0]     cfg_addr_i,
  input  wire logic [DATA_W-1:0]     cfg_wdata_i,
  input  wire logic [BE_W-1:0]       cfg_be_i,
  output logic      [DATA_W-1:0]     cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  input  wire logic [LTSSM_W-1:0]    port_ltssm_i [NUM_PORTS],
  input  wire logic                  id_load_i,
  input  wire logic [15:0]           id_vendor_i,
  input  wire logic [15:0]           id_device_i,
  input  wire logic [NUM_PINS-1:0]   pme_cap_en_i,
  input  wire logic [NUM_PINS-1:0]   port_power_i,
  input  wire logic [NUM_PINS-1:0]   gpio_in_i,
  output logic      [NUM_PINS-1:0]   gpio_out_o,
  output logic      [NUM_PINS-1:0]   gpio_oe_n_o
);

  logic              rst_meta;
  logic              rst_sync_n;
  uspm_state_t       s;
  uspm_state_t       next_s;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] dbg_ctrl_word;
  logic [DATA_W-1:0] pin_word;
  logic [LTSSM_W-1:0] sel_ltssm;
  logic [ADDR_W-1:0] word_addr;
  logic              up_ok;

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_comb begin
    wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    word_addr = {cfg_addr_i[ADDR_W-1:2], 2'h0} & ~{{(ADDR_W-2){1'b0}}, WORD_ALIGN_MASK};
    up_ok = cfg_up_i;
    sel_ltssm = port_ltssm_i[s.dbg_port];
    dbg_ctrl_word = RST_WORD32;
    dbg_ctrl_word[DBG_MODE_LSB +: DBG_MODE_W] = s.dbg_mode;
    dbg_ctrl_word[DBG_PORT_LSB +: PORT_SEL_W] = s.dbg_port;
    dbg_ctrl_word[DBG_START_BIT] = s.dbg_start;
    pin_word = RST_WORD32;
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_word[p*PIN_GROUP_W + PIN_IN_BIT]  = s.pin_in[p];
      pin_word[p*PIN_GROUP_W + PIN_OE_BIT]  = s.pin_oe[p];
      pin_word[p*PIN_GROUP_W + PIN_VAL_BIT] = s.pin_val[p];
    end
    rd_word = RST_WORD32;
    case (word_addr)
      OFF_EEPROM_WORD: rd_word = up_ok ? {s.ee_data, s.ee_addr} : RST_WORD32;
      OFF_DEBUG_CTRL:  rd_word = up_ok ? dbg_ctrl_word : RST_WORD32;
      OFF_DEBUG_VALUE: rd_word = up_ok ? s.dbg_value : RST_WORD32;
      OFF_SUBSYS_CAP: begin
        rd_word[CAP_ID_LSB +: 8]   = CAP_ID_SUBSYS;
        rd_word[CAP_NEXT_LSB +: 8] = CAP_NEXT_PTR;
      end
      OFF_SUBSYS_ID: begin
        rd_word[VENDOR_LSB +: 16] = s.vendor;
        rd_word[DEVICE_LSB +: 16] = s.device;
      end
      OFF_PIN_CTRL:    rd_word = up_ok ? pin_word : RST_WORD32;
      default:         rd_word = RST_WORD32;
    endcase
    wr_word = (rd_word & ~wmask) | (cfg_wdata_i & wmask);

    next_s = s;
    next_s.rvalid = cfg_rd_i;
    if (cfg_rd_i) begin
      next_s.rdata = rd_word;
    end
    if (cfg_wr_i && up_ok) begin
      case (word_addr)
        OFF_EEPROM_WORD: begin
          next_s.ee_data = wr_word[EE_DATA_LSB +: 16];
          next_s.ee_addr = wr_word[EE_ADDR_LSB +: 16];
        end
        OFF_DEBUG_CTRL: begin
          next_s.dbg_mode  = wr_word[DBG_MODE_LSB +: DBG_MODE_W];
          next_s.dbg_port  = wr_word[DBG_PORT_LSB +: PORT_SEL_W];
          next_s.dbg_start = wr_word[DBG_START_BIT];
        end
        OFF_PIN_CTRL: begin
          for (int p = 0; p < NUM_PINS; p++) begin
            next_s.pin_oe[p]  = wr_word[p*PIN_GROUP_W + PIN_OE_BIT];
            next_s.pin_val[p] = wr_word[p*PIN_GROUP_W + PIN_VAL_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (id_load_i) begin
      next_s.vendor = id_vendor_i;
      next_s.device = id_device_i;
    end
    next_s.dbg_value = RST_WORD32;
    if (s.dbg_start && (s.dbg_mode == DBG_MODE_LTSSM)) begin
      next_s.dbg_value[LTSSM_W-1:0] = sel_ltssm & LTSSM_MASK;
    end
    next_s.pin_in = gpio_in_i;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pme_cap_en_i[p]) begin
        next_s.pin_drive[p] = port_power_i[p];
        next_s.pin_oe_n[p]  = 1'b0;
      end else begin
        next_s.pin_drive[p] = s.pin_val[p];
        next_s.pin_oe_n[p]  = ~s.pin_oe[p];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s.ee_addr   <= RST_WORD16;
      s.ee_data   <= RST_WORD16;
      s.dbg_mode  <= '0;
      s.dbg_port  <= '0;
      s.dbg_start <= 1'b0;
      s.dbg_value <= RST_WORD32;
      s.vendor    <= RST_WORD16;
      s.device    <= RST_WORD16;
      s.pin_in    <= RST_PIN_IN;
      s.pin_oe    <= RST_PIN_OFF;
      s.pin_val   <= RST_PIN_OFF;
      s.pin_drive <= RST_PIN_OFF;
      s.pin_oe_n  <= RST_OE_N;
      s.rdata     <= RST_WORD32;
      s.rvalid    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign cfg_rdata_o  = s.rdata;
  assign cfg_rvalid_o = s.rvalid;
  assign gpio_out_o   = s.pin_drive;
  assign gpio_oe_n_o  = s.pin_oe_n;

endmodule

/* File: uspm_regs_assertions.sv */
// Checker bound to the upstream port register block.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/10ps
module uspm_regs_chk
  import uspm_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                cfg_up_i,
  input wire logic                cfg_rd_i,
  input wire logic [ADDR_W-1:0]   cfg_addr_i,
  input wire logic [DATA_W-1:0]   cfg_rdata_o,
  input wire logic                cfg_rvalid_o,
  input wire logic [NUM_PINS-1:0] pme_cap_en_i,
  input wire logic [NUM_PINS-1:0] port_power_i,
  input wire logic [NUM_PINS-1:0] gpio_out_o,
  input wire logic [NUM_PINS-1:0] gpio_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pwr1;
    $past(rst_n_i, 3) && pme_cap_en_i[1] && port_power_i[1];
  endsequence
  sequence s_drive1;
    gpio_out_o[1] && !gpio_oe_n_o[1];
  endsequence
  AST_RD_ANSWER: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  AST_RD_PULSE: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
    else $error("answer without read");
  AST_RD_HOLD: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data moved");
  AST_CAP_HDR: assert property (cfg_rd_i && cfg_addr_i[7:2] == 6'h2c
    |=> cfg_rdata_o == 32'h0000_c00d) else $error("bad capability header");
  AST_DOWN_ZERO: assert property (cfg_rd_i && !cfg_up_i
    && cfg_addr_i[7:2] inside {6'h29, 6'h2a, 6'h2b, 6'h2e} |=> cfg_rdata_o == 32'h0)
    else $error("downstream read not zero");
  AST_UNMAPPED: assert property (cfg_rd_i && cfg_addr_i < 8'ha4
    |=> cfg_rdata_o == 32'h0) else $error("unmapped read not zero");
  AST_PIN0_PWR: assert property ($past(rst_n_i, 3) && pme_cap_en_i[0]
    |=> !gpio_oe_n_o[0] && gpio_out_o[0] == $past(port_power_i[0]))
    else $error("pin 0 not following port power");
  AST_PIN1_PWR: assert property (s_pwr1 |=> s_drive1)
    else $error("pin 1 not following port power");
endmodule

bind uspm_regs uspm_regs_chk u_chk (.*);

/* File: uspm_regs_tb.sv */
// Testbench for the upstream port register block.
// Assumes a one-cycle read answer and registered pin outputs.
`timescale 1ns/10ps
module uspm_regs_tb;
  import uspm_pkg::*;
  logic                clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                cfg_up_i = 1'b1;
  logic                cfg_wr_i = 1'b0;
  logic                cfg_rd_i = 1'b0;
  logic                id_load_i = 1'b0;
  logic [ADDR_W-1:0]   cfg_addr_i = 8'h0;
  logic [DATA_W-1:0]   cfg_wdata_i = 32'h0;
  logic [BE_W-1:0]     cfg_be_i = 4'h0;
  logic [15:0]         id_vendor_i = 16'h0;
  logic [15:0]         id_device_i = 16'h0;
  logic [NUM_PINS-1:0] pme_cap_en_i = 2'h0;
  logic [NUM_PINS-1:0] port_power_i = 2'h0;
  logic [NUM_PINS-1:0] gpio_in_i = 2'h3;
  logic [LTSSM_W-1:0]  port_ltssm_i [NUM_PORTS];
  logic [DATA_W-1:0]   cfg_rdata_o;
  logic                cfg_rvalid_o;
  logic [NUM_PINS-1:0] gpio_out_o;
  logic [NUM_PINS-1:0] gpio_oe_n_o;
  int                  err_total = 0;
  int                  checks = 0;

  uspm_regs dut (.*);

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
                    input logic u);
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_be_i <= b;
    cfg_up_i <= u;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    cfg_up_i <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, input logic u, input logic [31:0] e);
    @(posedge clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_up_i <= u;
    @(posedge clk_i);
    cfg_rd_i <= 1'b0;
    cfg_up_i <= 1'b1;
    #1;
    chk("read valid", 32'(cfg_rvalid_o), 32'h1);
    chk($sformatf("read %h", a), cfg_rdata_o, e);
  endtask

  task automatic pins(input logic [1:0] o, input logic [1:0] n);
    @(posedge clk_i);
    #1;
    chk("pin out", 32'(gpio_out_o), 32'(o));
    chk("pin oe_n", 32'(gpio_oe_n_o), 32'(n));
  endtask

  initial begin
    foreach (port_ltssm_i[p]) port_ltssm_i[p] = 10'h3ff;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(8'ha4, 1'b1, 32'h0);
    rd(8'ha8, 1'b1, 32'h0);
    rd(8'hac, 1'b1, 32'h0);
    rd(8'hb0, 1'b0, 32'h0000_c00d);
    rd(8'hb8, 1'b1, 32'h11);
    wr(8'ha4, 32'ha5a5_1234, 4'hf, 1'b1);
    wr(8'ha4, 32'hffff_ffff, 4'h2, 1'b1);
    wr(8'ha4, 32'h0, 4'hf, 1'b0);
    wr(8'hb4, 32'hffff_ffff, 4'hf, 1'b1);
    wr(8'h10, 32'hffff_ffff, 4'hf, 1'b1);
    rd(8'ha4, 1'b1, 32'ha5a5_ff34);
    rd(8'ha4, 1'b0, 32'h0);
    rd(8'hb4, 1'b1, 32'h0);
    rd(8'h10, 1'b1, 32'h0);
    @(posedge clk_i);
    id_load_i <= 1'b1;
    id_vendor_i <= 16'h1234;
    id_device_i <= 16'habcd;
    @(posedge clk_i);
    id_load_i <= 1'b0;
    rd(8'hb4, 1'b1, 32'habcd_1234);
    wr(8'ha8, 32'hffff_ffff, 4'hf, 1'b1);
    rd(8'ha8, 1'b1, 32'h1ff);
    wr(8'ha8, 32'h1ac, 4'hf, 1'b1);
    for (int b = 0; b < 10; b++) begin
      @(posedge clk_i);
      port_ltssm_i[5] <= 10'(1 << b);
      rd(8'hac, 1'b1, 32'(10'h35f & 10'(1 << b)));
    end
    wr(8'ha8, 32'h1ab, 4'hf, 1'b1);
    rd(8'hac, 1'b1, 32'h0);
    wr(8'hb8, 32'h66, 4'hf, 1'b1);
    pins(2'h3, 2'h0);
    wr(8'hb8, 32'h22, 4'hf, 1'b1);
    pins(2'h0, 2'h0);
    wr(8'hb8, 32'h44, 4'hf, 1'b1);
    pins(2'h3, 2'h3);
    @(posedge clk_i);
    pme_cap_en_i <= 2'h3;
    port_power_i <= 2'h2;
    gpio_in_i <= 2'h1;
    pins(2'h2, 2'h0);
    rd(8'hb8, 1'b1, 32'h45);
    wr(8'hb8, 32'hffff_ffff, 4'hf, 1'b1);
    rd(8'hb8, 1'b1, 32'h67);
    final_report();
  end
endmodule
